// ### include/uaim_pkg.sv
// constants for the interrupt status and mask block
package uaim_pkg;

	// register indices; the byte address is four times the index
	localparam logic [7:0] IDX_G0_STAT = 8'h80;
	localparam logic [7:0] IDX_G1_STAT = 8'h90;
	localparam logic [7:0] IDX_G0_MASK = 8'h93;
	localparam logic [7:0] IDX_G1_MASK = 8'h94;
	localparam logic [7:0] IDX_REV     = 8'h95;
	localparam logic [7:0] IDX_ID      = 8'h96;

	// reset values
	localparam logic [7:0] G0_STAT_RST = 8'h0C;
	localparam logic [7:0] G1_STAT_RST = 8'h00;
	localparam logic [7:0] G0_MASK_RST = 8'hFF;
	localparam logic [7:0] G1_MASK_RST = 8'hFF;

	// bits that a written one acts on
	localparam logic [7:0] G0_W1_BITS = 8'h5F;
	localparam logic [7:0] G1_W1C_BITS = 8'h9F;

	// group-0 field positions
	localparam int G0_BUS_EVENT = 7;
	localparam int G0_SETUP     = 6;
	localparam int G0_DRIVE     = 4;
	localparam int G0_BUF_B_OUT = 3;
	localparam int G0_BUF_A_OUT = 2;
	localparam int G0_BUF_B_IN  = 1;
	localparam int G0_BUF_A_IN  = 0;

	// group-1 field positions
	localparam int G1_ZLP     = 7;
	localparam int G1_RSVD    = 6;
	localparam int G1_PIO     = 5;
	localparam int G1_BULK_RX = 4;
	localparam int G1_BULK_TX = 3;
	localparam int G1_CTRL_RX = 2;
	localparam int G1_CTRL_TX = 1;
	localparam int G1_SUSPEND = 0;

	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// suspend detection time
	localparam int CLK_PERIOD_NS   = 25;
	localparam int SUSPEND_IDLE_NS = 3_000_000;
	localparam int SUSPEND_IDLE_CYC = (SUSPEND_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ### logic/uaim_irq.sv
// interrupt status, mask and identification registers behind an axi4-lite slave
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module uaim_irq
	import uaim_pkg::*;
#(
	parameter int         ADDR_W      = 12,
	parameter int         IDLE_CYCLES = SUSPEND_IDLE_CYC,
	parameter logic [7:0] REVISION    = 8'h01, // arbitrary value
	parameter logic [7:0] IDENT       = 8'h5A  // arbitrary value
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              bus_event_pending,
	input  wire logic              setup_rx,
	input  wire logic              drive_interrupt_flag,
	input  wire logic              buffer_b_output_done,
	input  wire logic              buffer_a_output_done,
	input  wire logic              buffer_b_input_done,
	input  wire logic              buffer_a_input_done,
	input  wire logic              ctrl_zero_length_rx,
	input  wire logic              pio_transfer_done,
	input  wire logic              bulk_rx_done,
	input  wire logic              bulk_tx_done,
	input  wire logic              ctrl_rx_done,
	input  wire logic              ctrl_tx_done,
	input  wire logic              bus_idle,
	output logic                   core_irq_line_a,
	output logic                   core_irq_line_b,
	output logic                   bulk_out_nak,
	output logic                   bulk_in_nak,
	output logic                   ctrl_out_nak,
	output logic                   ctrl_in_nak
);

	localparam int CNT_W = $clog2(IDLE_CYCLES + 1);

	generate
		if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr
			$error("address width must lie between 10 and 32");
		end
		if (IDLE_CYCLES < 2) begin : g_bad_idle
			$error("idle cycle count must be at least 2");
		end
	endgenerate

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	////////////////////////////////////////////////////////////////////////
	// address decoding

	function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] addr);
		word_idx = addr[9:2];
	endfunction

	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
		logic [7:0] idx;
		idx = addr[9:2];
		reg_hit = (addr[1:0] == 2'h0) && ((ADDR_W == 10) || (addr >> 10) == '0) &&
			(idx == IDX_G0_STAT || idx == IDX_G1_STAT || idx == IDX_G0_MASK ||
			 idx == IDX_G1_MASK || idx == IDX_REV || idx == IDX_ID);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// write channel

	logic              awready_r;
	logic              wready_r;
	logic              bvalid_r;
	logic [1:0]        bresp_r;
	logic [ADDR_W-1:0] waddr_r;
	logic [31:0]       wdata_r;
	logic [3:0]        wstrb_r;
	logic              wr_go;
	logic              wr_lane0;
	logic [7:0]        wr_idx;

	// both address and data held, response not yet issued
	assign wr_go    = !awready_r && !wready_r && !bvalid_r;
	assign wr_lane0 = wr_go && reg_hit(waddr_r) && wstrb_r[0];
	assign wr_idx   = word_idx(waddr_r);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			waddr_r   <= '0;
		end else if (s_axi_awvalid && awready_r) begin
			awready_r <= 1'b0;
			waddr_r   <= s_axi_awaddr;
		end else if (bvalid_r && s_axi_bready) begin
			awready_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_r <= 1'b1;
			wdata_r  <= '0;
			wstrb_r  <= '0;
		end else if (s_axi_wvalid && wready_r) begin
			wready_r <= 1'b0;
			wdata_r  <= s_axi_wdata;
			wstrb_r  <= s_axi_wstrb;
		end else if (bvalid_r && s_axi_bready) begin
			wready_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r  <= reg_hit(waddr_r) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;

	////////////////////////////////////////////////////////////////////////
	// mask registers

	logic [7:0] g0_mask_r;
	logic [7:0] g1_mask_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			g0_mask_r <= G0_MASK_RST;
		end else if (wr_lane0 && wr_idx == IDX_G0_MASK) begin
			g0_mask_r <= wdata_r[7:0];
		end
	end

	// bit 6 is stored as written; software keeps it at one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			g1_mask_r <= G1_MASK_RST;
		end else if (wr_lane0 && wr_idx == IDX_G1_MASK) begin
			g1_mask_r <= wdata_r[7:0];
		end
	end

	a_mask_write_takes: assert property (
		(wr_lane0 && wr_idx == IDX_G0_MASK) |=> g0_mask_r == $past(wdata_r[7:0]))
		else $error("group-0 mask did not take the written value");

	////////////////////////////////////////////////////////////////////////
	// group-0 status

	logic [7:0] g0_stat_r;
	logic [7:0] g0_set;
	logic [7:0] g0_clr;
	logic [7:0] g0_view;

	always_comb begin
		g0_set                = 8'h00;
		g0_set[G0_SETUP]      = setup_rx;
		g0_set[G0_DRIVE]      = drive_interrupt_flag;
		g0_set[G0_BUF_B_OUT]  = buffer_b_output_done;
		g0_set[G0_BUF_A_OUT]  = buffer_a_output_done;
		g0_set[G0_BUF_B_IN]   = buffer_b_input_done;
		g0_set[G0_BUF_A_IN]   = buffer_a_input_done;
		g0_clr = (wr_lane0 && wr_idx == IDX_G0_STAT) ? (wdata_r[7:0] & G0_W1_BITS) : 8'h00;
	end

	// a written one restores the reset value; a new event wins over it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			g0_stat_r <= G0_STAT_RST;
		end else begin
			g0_stat_r <= (((g0_stat_r & ~g0_clr) | (g0_clr & G0_STAT_RST)) | g0_set)
				& G0_W1_BITS;
		end
	end

	// bus-event bit follows the separate bus status register
	always_comb begin
		g0_view               = g0_stat_r;
		g0_view[G0_BUS_EVENT] = bus_event_pending;
	end

	////////////////////////////////////////////////////////////////////////
	// suspend detection

	logic [CNT_W-1:0] idle_cnt_r;
	logic             suspend_hit;

	assign suspend_hit = bus_idle && idle_cnt_r == CNT_W'(IDLE_CYCLES - 1);

	// counts continuous idle; saturates so one idle period sets once
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			idle_cnt_r <= '0;
		end else if (!bus_idle) begin
			idle_cnt_r <= '0;
		end else if (idle_cnt_r != CNT_W'(IDLE_CYCLES)) begin
			idle_cnt_r <= idle_cnt_r + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// group-1 status

	logic [7:0] g1_stat_r;
	logic [7:0] g1_set;
	logic [7:0] g1_clr;
	logic [7:0] g1_view;

	always_comb begin
		g1_set              = 8'h00;
		g1_set[G1_ZLP]      = ctrl_zero_length_rx;
		g1_set[G1_BULK_RX]  = bulk_rx_done;
		g1_set[G1_BULK_TX]  = bulk_tx_done;
		g1_set[G1_CTRL_RX]  = ctrl_rx_done;
		g1_set[G1_CTRL_TX]  = ctrl_tx_done;
		g1_set[G1_SUSPEND]  = suspend_hit;
		g1_clr = (wr_lane0 && wr_idx == IDX_G1_STAT) ? (wdata_r[7:0] & G1_W1C_BITS) : 8'h00;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			g1_stat_r <= G1_STAT_RST;
		end else begin
			g1_stat_r <= ((g1_stat_r & ~g1_clr) | g1_set) & G1_W1C_BITS;
		end
	end

	always_comb begin
		g1_view           = g1_stat_r;
		g1_view[G1_RSVD]  = 1'b0;
		g1_view[G1_PIO]   = pio_transfer_done;
	end

	assign bulk_out_nak = g1_stat_r[G1_BULK_RX];
	assign bulk_in_nak  = g1_stat_r[G1_BULK_TX];
	assign ctrl_out_nak = g1_stat_r[G1_CTRL_RX];
	assign ctrl_in_nak  = g1_stat_r[G1_CTRL_TX];

	a_zlp_sets: assert property (ctrl_zero_length_rx |=> g1_stat_r[G1_ZLP])
		else $error("zero-length flag not set");

	a_suspend_sets: assert property (suspend_hit |=> g1_stat_r[G1_SUSPEND])
		else $error("suspend bit not set after idle time");

	a_bulk_out_nak: assert property (
		bulk_rx_done |=> bulk_out_nak && g1_stat_r[G1_BULK_RX])
		else $error("bulk out not naked after receive");

	a_ctrl_in_nak: assert property (
		(ctrl_tx_done && !g1_mask_r[G1_CTRL_TX] && !(wr_go && wr_idx == IDX_G1_MASK))
		|=> ctrl_in_nak ##1 core_irq_line_b)
		else $error("control in nak or interrupt missing");

	a_w1c_clears: assert property (
		(wr_lane0 && wr_idx == IDX_G1_STAT && wdata_r[G1_CTRL_RX] && !ctrl_rx_done)
		|=> !ctrl_out_nak)
		else $error("write one did not clear control receive flag");

	////////////////////////////////////////////////////////////////////////
	// interrupt lines

	logic irq_a_r;
	logic irq_b_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_a_r <= 1'b0;
			irq_b_r <= 1'b0;
		end else begin
			irq_a_r <= |(g0_view & ~g0_mask_r);
			irq_b_r <= |(g1_view & ~g1_mask_r);
		end
	end

	assign core_irq_line_a = irq_a_r;
	assign core_irq_line_b = irq_b_r;

	a_irq_b_follows: assert property (
		(|(g1_view & ~g1_mask_r)) |=> core_irq_line_b)
		else $error("group-1 line low with unmasked status");

	a_irq_b_drops: assert property (
		!(|(g1_view & ~g1_mask_r)) |=> !core_irq_line_b)
		else $error("group-1 line high without unmasked status");

	a_drive_gated: assert property (
		(drive_interrupt_flag && g0_mask_r[G0_DRIVE] && $stable(g0_mask_r)
		 && (g0_view & ~g0_mask_r) == 8'h00) |=> !core_irq_line_a)
		else $error("masked drive interrupt reached group-0 line");

	a_drive_passes: assert property (
		(drive_interrupt_flag && !g0_mask_r[G0_DRIVE] && !(wr_go && wr_idx == IDX_G0_MASK))
		|=> ##1 core_irq_line_a)
		else $error("unmasked drive interrupt did not reach group-0 line");

	////////////////////////////////////////////////////////////////////////
	// read channel

	logic        arready_r;
	logic        rvalid_r;
	logic [1:0]  rresp_r;
	logic [31:0] rdata_r;
	logic [7:0]  rd_val;
	logic [7:0]  rd_idx;

	assign rd_idx = word_idx(s_axi_araddr);

	always_comb begin
		case (rd_idx)
			IDX_G0_STAT: rd_val = g0_view;
			IDX_G1_STAT: rd_val = g1_view;
			IDX_G0_MASK: rd_val = g0_mask_r;
			IDX_G1_MASK: rd_val = g1_mask_r;
			IDX_REV:     rd_val = REVISION;
			IDX_ID:      rd_val = IDENT;
			default:     rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rresp_r   <= RESP_OKAY;
			rdata_r   <= '0;
		end else if (s_axi_arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rresp_r   <= reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			rdata_r   <= reg_hit(s_axi_araddr) ? {24'h00_0000, rd_val} : 32'h0000_0000;
		end else if (rvalid_r && s_axi_rready) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
		end
	end

	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rresp   = rresp_r;
	assign s_axi_rdata   = rdata_r;

	a_pio_mirror: assert property (
		(s_axi_arvalid && arready_r && reg_hit(s_axi_araddr) && rd_idx == IDX_G1_STAT)
		|=> s_axi_rdata[G1_PIO] == $past(pio_transfer_done) && !s_axi_rdata[G1_RSVD])
		else $error("pio mirror or reserved bit wrong on read");

	a_ident_fixed: assert property (
		(s_axi_arvalid && arready_r && reg_hit(s_axi_araddr) && rd_idx == IDX_ID)
		|=> s_axi_rdata == {24'h00_0000, IDENT})
		else $error("identification read wrong");

endmodule

// ### dv/uaim_core_model.sv
// behavioural model of the processor core's two interrupt inputs
`timescale 1ns/1ps
module uaim_core_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       irq_a,
	input  wire logic       irq_b,
	output logic [1:0]      irq_q
);
	// level-sensitive inputs, sampled once a cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_q <= 2'b00;
		end else begin
			irq_q <= {irq_b, irq_a};
		end
	end
endmodule

// ### dv/tb_top.sv
// self-checking bench for the interrupt status and mask block
`timescale 1ns/1ps
module tb_top
	import uaim_pkg::*;
;
	logic        aclk;
	logic        aresetn;
	logic [11:0] awaddr;
	logic [11:0] araddr;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, irq_q;
	logic [7:0]  g0_ev, g1_ev;
	logic [3:0]  nak;
	logic        irq_a, irq_b;
	int          errors = 0;
	int          samples_checked = 0;

	uaim_irq #(.IDLE_CYCLES(16), .REVISION(8'h3C), .IDENT(8'hC3)) dut_u (.aclk(aclk),
		.aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .bus_event_pending(g0_ev[7]), .setup_rx(g0_ev[6]),
		.drive_interrupt_flag(g0_ev[4]), .buffer_b_output_done(g0_ev[3]),
		.buffer_a_output_done(g0_ev[2]), .buffer_b_input_done(g0_ev[1]),
		.buffer_a_input_done(g0_ev[0]), .ctrl_zero_length_rx(g1_ev[7]),
		.pio_transfer_done(g1_ev[5]), .bulk_rx_done(g1_ev[4]), .bulk_tx_done(g1_ev[3]),
		.ctrl_rx_done(g1_ev[2]), .ctrl_tx_done(g1_ev[1]), .bus_idle(g1_ev[0]),
		.core_irq_line_a(irq_a), .core_irq_line_b(irq_b), .bulk_out_nak(nak[3]),
		.bulk_in_nak(nak[2]), .ctrl_out_nak(nak[1]), .ctrl_in_nak(nak[0]));

	uaim_core_model core_u (.aclk(aclk), .aresetn(aresetn), .irq_a(irq_a), .irq_b(irq_b),
		.irq_q(irq_q));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	task automatic print_verdict;
		if (errors == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge aclk);
		errors++;
		print_verdict();
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [11:0] ad(input logic [7:0] i);
		return {2'b00, i, 2'b00};
	endfunction

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	// waits for the answer without limit; only the watchdog ends a hang
	task automatic wr(input logic [7:0] i, input logic [7:0] d, output logic [1:0] r);
		awaddr <= ad(i);
		wdata <= {24'h0, d};
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		r = bresp;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
		araddr <= ad(i);
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
		@(posedge aclk);
	endtask

	// read a register and compare the whole word with the zero-extended byte and an okay answer
	task automatic rchk(input string n, input logic [7:0] i, input logic [7:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(i, d, r);
		chk(n, {24'h0, e}, d);
		chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [1:0]  r;
		logic [31:0] d;
		logic [7:0]  m, ex, base, si;
		logic        lvl;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata, wstrb} = '0;
		g0_ev = 8'h00;
		g1_ev = 8'h00;
		void'($urandom(32'h92c0_8d38));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rchk("g0_mask", IDX_G0_MASK, 8'hFF);
		rchk("g1_mask", IDX_G1_MASK, 8'hFF);
		rchk("g1_stat", IDX_G1_STAT, 8'h00);
		rchk("g0_stat", IDX_G0_STAT, 8'h0C);
		wr(IDX_REV, 8'hA5, r);
		wr(IDX_ID, 8'h5A, r);
		rchk("revision", IDX_REV, 8'h3C);
		rchk("ident", IDX_ID, 8'hC3);
		wr(IDX_G1_STAT, 8'hFF, r);
		rchk("g1_rsvd", IDX_G1_STAT, 8'h00);
		wr(8'h91, 8'hFF, r);
		chk("bresp_unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
		rd(8'h91, d, r);
		chk("rresp_unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
		// idle shorter than the suspend time must not set bit 0
		g1_ev[0] <= 1'b1;
		repeat (12) @(posedge aclk);
		g1_ev[0] <= 1'b0;
		rchk("short_idle", IDX_G1_STAT, 8'h00);
		// masked drive interrupt sets status only; unmasking it raises the line
		wr(IDX_G0_MASK, 8'hFF, r);
		g0_ev[4] <= 1'b1;
		@(posedge aclk);
		g0_ev[4] <= 1'b0;
		repeat (3) @(posedge aclk);
		chk("drive_masked", 32'h0, {31'h0, irq_q[0]});
		rchk("drive_stat", IDX_G0_STAT, 8'h1C);
		wr(IDX_G0_MASK, 8'hEF, r);
		g0_ev[4] <= 1'b1;
		@(posedge aclk);
		g0_ev[4] <= 1'b0;
		repeat (3) @(posedge aclk);
		chk("drive_open", 32'h1, {31'h0, irq_q[0]});
		wr(IDX_G0_STAT, 8'h10, r);
		repeat (3) @(posedge aclk);
		chk("drive_clr", 32'h0, {31'h0, irq_q[0]});
		for (int g = 0; g < 2; g++) begin
			for (int b = 0; b < 8; b++) begin
				if (b == 5 + g) continue;
				si = g ? IDX_G1_STAT : IDX_G0_STAT;
				base = g ? 8'h00 : 8'h0C;
				lvl = (b == 7 - 2 * g);
				m = 8'($urandom);
				m[6] = 1'b1;
				m[b] = 1'($urandom);
				wr(g ? IDX_G1_MASK : IDX_G0_MASK, m, r);
				chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
				rchk("mask", g ? IDX_G1_MASK : IDX_G0_MASK, m);
				if (g) g1_ev[b] <= 1'b1;
				else g0_ev[b] <= 1'b1;
				repeat ((g && b == 0) ? 20 : 1) @(posedge aclk);
				if (!lvl) g0_ev <= 8'h00;
				if (!lvl) g1_ev <= 8'h00;
				ex = base | (8'h01 << b);
				repeat (3) @(posedge aclk);
				chk("irq_set", {31'h0, |(ex & ~m)}, {31'h0, irq_q[g]});
				rchk("status_set", si, ex);
				if (g) chk("nak_set", {28'h0, ex[4:1]}, {28'h0, nak});
				wr(si, 8'h01 << b, r);
				if (lvl) begin
					rchk("status_held", si, ex);
					g0_ev <= 8'h00;
					g1_ev <= 8'h00;
				end
				repeat (3) @(posedge aclk);
				rchk("status_clr", si, base);
				chk("irq_clr", {31'h0, |(base & ~m)}, {31'h0, irq_q[g]});
				if (g) chk("nak_clr", 32'h0, {28'h0, nak});
			end
		end
		// second reset in mid-run brings the masks back to all ones
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rchk("g0_mask_rst", IDX_G0_MASK, 8'hFF);
		rchk("g1_mask_rst", IDX_G1_MASK, 8'hFF);
		print_verdict();
	end
endmodule
